/* rtl/fcs_consts.svh */
// constants for the flash command sequencer
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// command addresses (low 16 bits of the bus address)
`define FCS_A_UNLK1   16'h5400
`define FCS_A_UNLK2   16'haa00
// command data words
`define FCS_D_UNLK1   32'h0000_00aa
`define FCS_D_UNLK2   32'h0000_0055
`define FCS_D_PAGE    32'h0000_00a0
`define FCS_D_ERASE   32'h0000_0080
`define FCS_D_CHIP    32'h0000_0010
`define FCS_D_BLOCK   32'h0000_0030
`define FCS_D_PPROG   32'h0000_009a
`define FCS_D_PERASE  32'h0000_006a
`define FCS_D_RESET   32'h0000_00f0
// bus write cycle index, first cycle is 0
`define FCS_C1        3'd0
`define FCS_C2        3'd1
`define FCS_C3        3'd2
`define FCS_C4        3'd3
`define FCS_C5        3'd4
`define FCS_C6        3'd5
`define FCS_C7        3'd6
`define FCS_C_STEP    3'd1
// page layout: 128 words, page offset bits [8:0]
`define FCS_PG_OFS    9'h000
`define FCS_W_FIRST   7'h00
`define FCS_W_LAST    7'h7f
`define FCS_W_STEP    7'h01
// block base addresses
`define FCS_B0_BASE   19'h00000
`define FCS_B1_BASE   19'h08000
`define FCS_B2_BASE   19'h10000
`define FCS_B3_BASE   19'h20000
`define FCS_B4_BASE   19'h40000
`define FCS_B5_BASE   19'h60000
`define FCS_BLK_NONE  6'h00
`define FCS_BLK_ALL   6'h3f
// status word layout and reset values
`define FCS_ST_ZERO_HI 10'h000
`define FCS_ST_ZERO_LO 15'h0000
`define FCS_RDY_RESET  1'b1
`endif

/* rtl/fcs_pkg.sv */
// types of the flash command sequencer
package fcs_pkg;
	// sequencer mode
	typedef enum logic [2:0] {ST_READ, ST_CMD, ST_PAGE, ST_RUN, ST_LOCK} fcs_state_t;
	// command family chosen at the third cycle
	typedef enum logic [1:0] {K_ERASE, K_PPROG, K_PERASE, K_NONE} fcs_kind_t;
	// automatic operation handed to the engine
	typedef enum logic [1:0] {OP_PAGE, OP_ERASE, OP_PPROG, OP_PERASE} fcs_op_t;
	// single array step
	typedef enum logic [1:0] {A_WORD, A_BLOCK, A_PBIT_SET, A_PBIT_CLR} fcs_arr_t;
	// engine state
	typedef enum logic [1:0] {E_IDLE, E_NEXT, E_SET, E_REQ} fcs_eng_t;
endpackage : fcs_pkg

/* rtl/fcs_op_engine.sv */
// automatic operation engine: walks words or blocks on the array
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_op_engine import fcs_pkg::*; (
	// clock, reset, enable
	input  wire logic       sys_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       ce_in,
	// operation start
	input  wire logic       start_in,
	input  wire fcs_op_t    op_in,
	input  wire logic [5:0] blk_mask_in,
	input  wire logic [2:0] prot_blk_in,
	// array handshake
	input  wire logic       arr_ack_in,
	input  wire logic       arr_fail_in,
	output fcs_arr_t        arr_kind_out,
	output logic            arr_req_out,
	output logic      [2:0] arr_blk_out,
	output logic      [6:0] word_idx_out,
	// completion
	output logic            done_out,
	output logic            fail_out
);
	fcs_eng_t   state;     // engine state
	fcs_op_t    op;        // latched operation
	logic [5:0] mask;      // blocks still to erase
	logic       pclr_done; // protect bits already cleared

	///////////////////////////////////////////////////////////////////////////
	// step sequencing
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state        <= E_IDLE;
			op           <= OP_PAGE;
			mask         <= `FCS_BLK_NONE;
			pclr_done    <= 1'b0;
			arr_kind_out <= A_WORD;
			arr_req_out  <= 1'b0;
			arr_blk_out  <= 3'h0;
			word_idx_out <= `FCS_W_FIRST;
			done_out     <= 1'b0;
			fail_out     <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			fail_out <= 1'b0;
			case (state)
				E_IDLE: if (start_in) begin
					op           <= op_in;
					mask         <= blk_mask_in;
					pclr_done    <= 1'b0;
					arr_blk_out  <= prot_blk_in;
					word_idx_out <= `FCS_W_FIRST;
					state        <= E_NEXT;
				end
				E_NEXT: begin
					state <= E_SET;
					case (op)
						OP_PAGE:  arr_kind_out <= A_WORD;
						OP_PPROG: arr_kind_out <= A_PBIT_SET;
						default: begin
							// lowest pending block first
							arr_kind_out <= A_BLOCK;
							if (mask[0]) begin arr_blk_out <= 3'd0; mask[0] <= 1'b0; end
							else if (mask[1]) begin arr_blk_out <= 3'd1; mask[1] <= 1'b0; end
							else if (mask[2]) begin arr_blk_out <= 3'd2; mask[2] <= 1'b0; end
							else if (mask[3]) begin arr_blk_out <= 3'd3; mask[3] <= 1'b0; end
							else if (mask[4]) begin arr_blk_out <= 3'd4; mask[4] <= 1'b0; end
							else if (mask[5]) begin arr_blk_out <= 3'd5; mask[5] <= 1'b0; end
							else if (op == OP_PERASE && !pclr_done) begin
								arr_kind_out <= A_PBIT_CLR;
								pclr_done    <= 1'b1;
							end else begin
								done_out <= 1'b1;
								state    <= E_IDLE;
							end
						end
					endcase
				end
				// address and data settle one cycle before the request
				E_SET: begin
					arr_req_out <= 1'b1;
					state       <= E_REQ;
				end
				E_REQ: if (arr_ack_in) begin
					arr_req_out <= 1'b0;
					if (arr_fail_in) begin
						fail_out <= 1'b1;
						state    <= E_IDLE;
					end else if (op == OP_PPROG ||
						(op == OP_PAGE && word_idx_out == `FCS_W_LAST)) begin
						done_out <= 1'b1;
						state    <= E_IDLE;
					end else begin
						if (op == OP_PAGE)
							word_idx_out <= word_idx_out + `FCS_W_STEP;
						state <= E_NEXT;
					end
				end
				default: state <= E_IDLE;
			endcase
		end
	end
endmodule : fcs_op_engine

/* rtl/fcs_sequencer.sv */
// flash command sequencer: command recognition, page buffer, status
//
// Behaviour
// - hardware reset aborts operation, enters read mode
// - array readable right after reset release
// - programming only clears bits; erase sets them
// - page is 128 words sharing address 31:9
// - third page-program cycle enters page programming
// - fourth cycle page top, then consecutive words
// - normal page completion sets ready, read mode
// - new commands ignored during automatic operation
// - one command programs exactly one page
// - protected block words never programmed
// - failure locks busy until hardware reset
// - no software reset from fourth page cycle
// - chip erase starts after sixth cycle
// - chip erase skips protected; none returns immediately
// - block erase after sixth cycle, not protected
// - seventh cycle address picks protect bit
// - all protected refuses page program, block and chip erase
// - seventh protect cycle: busy, reset ignored
// - protect erase depends on security, all-set
// - ready low while running, held on failure
// - off-sequence write returns to read mode
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_sequencer import fcs_pkg::*; (
	// clock, reset, enable
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        ce_in,
	// cpu bus write cycles
	input  wire logic        bus_wr_in,
	input  wire logic [31:0] bus_addr_in,
	input  wire logic [31:0] bus_wdata_in,
	// nonvolatile state from the array
	input  wire logic [5:0]  prot_init_in,
	input  wire logic        security_enable_bit_in,
	// array step handshake
	input  wire logic        arr_ack_in,
	input  wire logic        arr_fail_in,
	output logic             arr_req_out,
	output fcs_arr_t         arr_kind_out,
	output logic [31:0]      arr_addr_out,
	output logic [31:0]      arr_clr_mask_out,
	// status
	output logic [31:0]      flash_ctrl_status_reg_out,
	output logic             auto_op_done_flag_out,
	output logic [5:0]       block_protect_bits_out,
	output logic             read_mode_out
);
	fcs_state_t  state, next_state;  // sequencer mode
	fcs_kind_t   kind, next_kind;    // command family
	logic [2:0]  cyc, next_cyc;      // bus write cycle counter
	logic [22:0] page_top;           // page address bits 31:9
	logic [6:0]  widx;               // next page word slot
	logic [31:0] page_buf [0:127];   // page data buffer
	logic [5:0]  prot;               // protection bits
	logic        flag;               // ready flag
	logic        go;                 // start the engine
	fcs_op_t     go_op;              // engine operation
	logic [5:0]  go_mask;            // blocks to erase
	logic [2:0]  go_blk;             // protect bit to program
	logic        word_ok;            // page word accepted
	logic        sw_reset;           // software read/reset seen
	logic        eng_done, eng_fail; // engine completion
	logic        eng_req;            // engine request level
	fcs_arr_t    eng_kind;           // engine step kind
	logic [2:0]  eng_blk;            // engine block
	logic [6:0]  eng_idx;            // engine word index

	///////////////////////////////////////////////////////////////////////////
	// helpers
	// block holding an array address
	function automatic logic [2:0] blk_of(input logic [31:0] a);
		if (a[18:0] >= `FCS_B5_BASE)      blk_of = 3'd5;
		else if (a[18:0] >= `FCS_B4_BASE) blk_of = 3'd4;
		else if (a[18:0] >= `FCS_B3_BASE) blk_of = 3'd3;
		else if (a[18:0] >= `FCS_B2_BASE) blk_of = 3'd2;
		else if (a[18:0] >= `FCS_B1_BASE) blk_of = 3'd1;
		else                              blk_of = 3'd0;
	endfunction : blk_of

	// base address of a block
	function automatic logic [18:0] blk_base(input logic [2:0] b);
		case (b)
			3'd1:    blk_base = `FCS_B1_BASE;
			3'd2:    blk_base = `FCS_B2_BASE;
			3'd3:    blk_base = `FCS_B3_BASE;
			3'd4:    blk_base = `FCS_B4_BASE;
			3'd5:    blk_base = `FCS_B5_BASE;
			default: blk_base = `FCS_B0_BASE;
		endcase
	endfunction : blk_base

	// command address and data match
	function automatic logic hit(input logic [31:0] a, input logic [31:0] d,
		input logic [15:0] ea, input logic [31:0] ed);
		hit = (a[15:0] == ea) && (d == ed);
	endfunction : hit

	///////////////////////////////////////////////////////////////////////////
	// command recognition
	always_comb begin
		next_state = state;
		next_kind  = kind;
		next_cyc   = cyc;
		go         = 1'b0;
		go_op      = OP_PAGE;
		go_mask    = `FCS_BLK_NONE;
		go_blk     = 3'h0;
		word_ok    = 1'b0;
		// seventh protect cycle ignores software reset
		sw_reset   = (bus_wdata_in == `FCS_D_RESET) &&
			!(cyc == `FCS_C7 && kind == K_PPROG);
		if (bus_wr_in) begin
			case (state)
				ST_READ, ST_CMD: begin
					// any off-sequence write falls back to read mode
					next_state = ST_READ;
					next_cyc   = `FCS_C1;
					next_kind  = K_NONE;
					if (!sw_reset) begin
						case (cyc)
							`FCS_C1, `FCS_C4: if (hit(bus_addr_in, bus_wdata_in,
								`FCS_A_UNLK1, `FCS_D_UNLK1) && (cyc == `FCS_C1 || kind != K_NONE)) begin
								next_state = ST_CMD;
								next_kind  = kind;
								next_cyc   = cyc + `FCS_C_STEP;
							end
							`FCS_C2, `FCS_C5: if (hit(bus_addr_in, bus_wdata_in,
								`FCS_A_UNLK2, `FCS_D_UNLK2)) begin
								next_state = ST_CMD;
								next_kind  = kind;
								next_cyc   = cyc + `FCS_C_STEP;
							end
							`FCS_C3: if (bus_addr_in[15:0] == `FCS_A_UNLK1) begin
								next_state = ST_CMD;
								next_cyc   = cyc + `FCS_C_STEP;
								case (bus_wdata_in)
									`FCS_D_PAGE: begin
										next_state = ST_PAGE;
										next_cyc   = `FCS_C4;
									end
									`FCS_D_ERASE:  next_kind = K_ERASE;
									`FCS_D_PPROG:  next_kind = K_PPROG;
									`FCS_D_PERASE: next_kind = K_PERASE;
									default: begin
										next_state = ST_READ;
										next_cyc   = `FCS_C1;
									end
								endcase
							end
							`FCS_C6: begin
								if (kind == K_ERASE && hit(bus_addr_in, bus_wdata_in,
									`FCS_A_UNLK1, `FCS_D_CHIP)) begin
									go_mask = ~prot;
									go_op   = OP_ERASE;
									go      = (go_mask != `FCS_BLK_NONE);
								end else if (kind == K_ERASE &&
									bus_wdata_in == `FCS_D_BLOCK) begin
									go_op   = OP_ERASE;
									go_mask = `FCS_BLK_NONE;
									go_mask[blk_of(bus_addr_in)] = 1'b1;
									go      = !prot[blk_of(bus_addr_in)];
								end else if ((kind == K_PPROG && hit(bus_addr_in,
									bus_wdata_in, `FCS_A_UNLK1, `FCS_D_PPROG)) ||
									(kind == K_PERASE && hit(bus_addr_in,
									bus_wdata_in, `FCS_A_UNLK1, `FCS_D_PERASE))) begin
									next_state = ST_CMD;
									next_kind  = kind;
									next_cyc   = `FCS_C7;
								end
							end
							`FCS_C7: begin
								if (kind == K_PPROG) begin
									go_op  = OP_PPROG;
									go_blk = blk_of(bus_addr_in);
									go     = 1'b1;
								end else if (kind == K_PERASE &&
									bus_wdata_in == `FCS_D_PERASE) begin
									go_op   = OP_PERASE;
									go_mask = (security_enable_bit_in && &prot) ?
										`FCS_BLK_ALL : `FCS_BLK_NONE;
									go      = 1'b1;
								end
							end
							default: ;
						endcase
					end
				end
				// page words: no software reset here
				ST_PAGE: begin
					word_ok = 1'b1;
					if (widx == `FCS_W_FIRST &&
						(bus_addr_in[8:0] != `FCS_PG_OFS ||
						prot[blk_of(bus_addr_in)])) begin
						word_ok    = 1'b0;
						next_state = ST_READ;
						next_cyc   = `FCS_C1;
					end else if (widx == `FCS_W_LAST) begin
						go    = 1'b1;
						go_op = OP_PAGE;
					end
				end
				default: ;
			endcase
		end
		if (go)
			next_state = ST_RUN;
		if (state == ST_RUN) begin
			if (eng_fail) begin
				next_state = ST_LOCK;
			end else if (eng_done) begin
				next_state = ST_READ;
				next_cyc   = `FCS_C1;
				next_kind  = K_NONE;
			end
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// mode registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state <= ST_READ;
			kind  <= K_NONE;
			cyc   <= `FCS_C1;
		end else if (ce_in) begin
			state <= next_state;
			kind  <= next_kind;
			cyc   <= next_cyc;
		end
	end

	// page buffer fill, one word per bus cycle
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			widx     <= `FCS_W_FIRST;
			page_top <= 23'h000000;
		end else if (ce_in) begin
			if (state != ST_PAGE) begin
				widx <= `FCS_W_FIRST;
			end else if (word_ok) begin
				if (widx == `FCS_W_FIRST)
					page_top <= bus_addr_in[31:9];
				page_buf[widx] <= bus_wdata_in;
				widx           <= widx + `FCS_W_STEP;
			end
		end
	end

	// protection bits follow completed protect steps
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			prot <= prot_init_in;
		end else if (ce_in && eng_req && arr_ack_in && !arr_fail_in) begin
			if (eng_kind == A_PBIT_SET)
				prot[eng_blk] <= 1'b1;
			else if (eng_kind == A_PBIT_CLR)
				prot <= `FCS_BLK_NONE;
		end
	end

	// ready flag: low from busy entry, held low on failure
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			flag <= `FCS_RDY_RESET;
		end else if (ce_in) begin
			if (go || (word_ok && widx == `FCS_W_FIRST))
				flag <= 1'b0;
			else if (state == ST_RUN && eng_done && !eng_fail)
				flag <= 1'b1;
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// operation engine
	fcs_op_engine u_engine (
		.sys_clk_in   (sys_clk_in),
		.rst_b_in     (rst_b_in),
		.ce_in        (ce_in),
		.start_in     (go),
		.op_in        (go_op),
		.blk_mask_in  (go_mask),
		.prot_blk_in  (go_blk),
		.arr_ack_in   (arr_ack_in),
		.arr_fail_in  (arr_fail_in),
		.arr_kind_out (eng_kind),
		.arr_req_out  (eng_req),
		.arr_blk_out  (eng_blk),
		.word_idx_out (eng_idx),
		.done_out     (eng_done),
		.fail_out     (eng_fail)
	);

	///////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			arr_req_out      <= 1'b0;
			arr_kind_out     <= A_WORD;
			arr_addr_out     <= 32'h0000_0000;
			arr_clr_mask_out <= 32'h0000_0000;
		end else if (ce_in) begin
			arr_req_out  <= eng_req && !arr_ack_in;
			arr_kind_out <= eng_kind;
			if (eng_kind == A_WORD)
				arr_addr_out <= {page_top, eng_idx, 2'b00};
			else
				arr_addr_out <= {13'h0000, blk_base(eng_blk)};
			// a zero data bit clears its cell; ones leave cells alone
			arr_clr_mask_out <= ~page_buf[eng_idx];
		end
	end

	// status outputs
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			auto_op_done_flag_out     <= `FCS_RDY_RESET;
			block_protect_bits_out    <= `FCS_BLK_NONE;
			flash_ctrl_status_reg_out <= {`FCS_ST_ZERO_HI, `FCS_BLK_NONE,
				`FCS_ST_ZERO_LO, `FCS_RDY_RESET};
			read_mode_out             <= 1'b1;
		end else if (ce_in) begin
			auto_op_done_flag_out     <= flag;
			block_protect_bits_out    <= prot;
			flash_ctrl_status_reg_out <= {`FCS_ST_ZERO_HI, prot,
				`FCS_ST_ZERO_LO, flag};
			read_mode_out <= (state == ST_READ) || (state == ST_CMD);
		end
	end
endmodule : fcs_sequencer

/* bench/fcs_array_model.sv */
// behavioural array model: answers step requests, tallies what was done
`timescale 1ns/1ps
module fcs_array_model import fcs_pkg::*; (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	// step request from the sequencer
	input  wire logic        arr_req_in,
	input  wire fcs_arr_t    arr_kind_in,
	input  wire logic [31:0] arr_addr_in,
	input  wire logic [31:0] arr_clr_mask_in,
	output logic             arr_ack_out,
	output logic             arr_fail_out,
	// bench controls
	input  wire logic [3:0]  delay_in,
	input  wire logic        fail_in,
	// tally of finished steps
	output logic [15:0]      step_cnt_out,
	output logic [15:0]      blk_cnt_out,
	output logic [31:0]      sum_out
);
	logic [3:0] wait_cnt; // cycles spent on the current step
	////////////////////////////////////////////////////////////////
	// one ack pulse per step after the chosen delay
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			arr_ack_out <= 1'b0;
			wait_cnt    <= 4'h0;
		end else if (arr_req_in && !arr_ack_out && wait_cnt >= delay_in) begin
			arr_ack_out <= 1'b1;
			wait_cnt    <= 4'h0;
		end else begin
			arr_ack_out <= 1'b0;
			wait_cnt    <= (arr_req_in && !arr_ack_out) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
	// fail is only meaningful with ack; garbage otherwise
	assign arr_fail_out = arr_ack_out ? fail_in : ~fail_in;
	////////////////////////////////////////////////////////////////
	// tally steps; words add address xor clear mask, blocks their base
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			step_cnt_out <= 16'h0000;
			blk_cnt_out  <= 16'h0000;
			sum_out      <= 32'h0000_0000;
		end else if (arr_req_in && arr_ack_out) begin
			step_cnt_out <= step_cnt_out + 16'h0001;
			blk_cnt_out  <= blk_cnt_out + {15'h0000, arr_kind_in == A_BLOCK};
			sum_out      <= sum_out + ((arr_kind_in == A_WORD) ?
				arr_addr_in ^ arr_clr_mask_in : {13'h0000, arr_addr_in[18:0]});
		end
	end
endmodule : fcs_array_model

/* bench/fcs_seq_props.sv */
// port assertions for the flash command sequencer
`timescale 1ns/1ps
module fcs_seq_props import fcs_pkg::*; (
	// clock, reset, enable
	input wire logic        sys_clk_in,
	input wire logic        rst_b_in,
	input wire logic        ce_in,
	// array handshake
	input wire logic        arr_ack_in,
	input wire logic        arr_fail_in,
	input wire logic        arr_req_out,
	input wire logic [31:0] arr_addr_out,
	input wire logic [31:0] arr_clr_mask_out,
	// status
	input wire logic [31:0] flash_ctrl_status_reg_out,
	input wire logic        auto_op_done_flag_out,
	input wire logic [5:0]  block_protect_bits_out,
	input wire logic        read_mode_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////////////////////////////
	// reset returns to idle read mode
	chk_reset_idle: assert property (disable iff (1'b0) !rst_b_in |=>
		auto_op_done_flag_out && read_mode_out && !arr_req_out)
		else $error("reset did not give idle read mode");
	// request and its address and mask hold until ack
	chk_req_held: assert property (arr_req_out && !arr_ack_in |=>
		arr_req_out && $stable(arr_addr_out) && $stable(arr_clr_mask_out))
		else $error("array request changed before ack");
	// request drops the edge after ack
	chk_req_drop: assert property (arr_req_out && arr_ack_in && ce_in |=> !arr_req_out)
		else $error("array request not dropped after ack");
	// status word layout
	chk_status_map: assert property (flash_ctrl_status_reg_out ==
		{10'h000, block_protect_bits_out, 15'h0000, auto_op_done_flag_out})
		else $error("status word layout wrong");
	// a running step means busy and not read mode
	chk_busy_req: assert property (arr_req_out |-> !auto_op_done_flag_out && !read_mode_out)
		else $error("array step while ready or in read mode");
	// failure locks busy
	chk_fail_lock: assert property (arr_req_out && arr_ack_in && arr_fail_in && ce_in |=>
		(!auto_op_done_flag_out && !read_mode_out) [*8])
		else $error("failed step did not lock busy");
	// ready falls only when leaving read mode
	chk_ready_fall: assert property ($fell(auto_op_done_flag_out) |-> !read_mode_out)
		else $error("ready fell in read mode");
	// ready returns together with read mode
	chk_ready_rise: assert property ($rose(auto_op_done_flag_out) |->
		read_mode_out && !arr_req_out)
		else $error("ready rose without read mode");
	// protect bits move only while busy or from reset load
	chk_prot_move: assert property ($changed(block_protect_bits_out) |->
		!$past(auto_op_done_flag_out) || !$past(rst_b_in) || !$past(rst_b_in, 2))
		else $error("protect bits changed while idle");
	////////////////////////////////////////////////////////////////
	// main scenarios reached
	cov_op_done: cover property ($rose(auto_op_done_flag_out));
	cov_op_fail: cover property (arr_req_out && arr_ack_in && arr_fail_in);
	cov_prot_move: cover property ($changed(block_protect_bits_out));
endmodule : fcs_seq_props
bind fcs_sequencer fcs_seq_props u_fcs_seq_props (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
	.arr_ack_in(arr_ack_in), .arr_fail_in(arr_fail_in), .arr_req_out(arr_req_out),
	.arr_addr_out(arr_addr_out), .arr_clr_mask_out(arr_clr_mask_out),
	.flash_ctrl_status_reg_out(flash_ctrl_status_reg_out),
	.auto_op_done_flag_out(auto_op_done_flag_out),
	.block_protect_bits_out(block_protect_bits_out), .read_mode_out(read_mode_out));

/* bench/test_flash_command_sequencer.sv */
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_consts.svh"
module test_flash_command_sequencer import fcs_pkg::*;;
	logic        clk, rst_b, ce, wr_s, sec, ack, fail_w, req, rdy, rmode, fail_en;
	logic [31:0] addr, wdata, aaddr, mask, status, sum, s0, d, a, exp_sum;
	logic [5:0]  prot_init, pbits;
	logic [15:0] cnt, bcnt, c0, b0;
	logic [3:0]  dly;
	fcs_arr_t    kind;
	int          fail_count, comparisons, cycles;
	localparam logic [31:0] a_u1 = {16'h0000, `FCS_A_UNLK1}; // command address
	////////////////////////////////////////////////////////////////
	fcs_sequencer dut (.sys_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .bus_wr_in(wr_s),
		.bus_addr_in(addr), .bus_wdata_in(wdata), .prot_init_in(prot_init),
		.security_enable_bit_in(sec), .arr_ack_in(ack), .arr_fail_in(fail_w),
		.arr_req_out(req), .arr_kind_out(kind), .arr_addr_out(aaddr),
		.arr_clr_mask_out(mask), .flash_ctrl_status_reg_out(status),
		.auto_op_done_flag_out(rdy), .block_protect_bits_out(pbits), .read_mode_out(rmode));
	fcs_array_model u_array (.sys_clk_in(clk), .rst_b_in(rst_b), .arr_req_in(req),
		.arr_kind_in(kind), .arr_addr_in(aaddr), .arr_clr_mask_in(mask),
		.arr_ack_out(ack), .arr_fail_out(fail_w), .delay_in(dly), .fail_in(fail_en),
		.step_cnt_out(cnt), .blk_cnt_out(bcnt), .sum_out(sum));
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	// closing report
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		comparisons++;
		if (got !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : chk
	// one bus write; strobe left high for back to back writes
	task automatic wr(input logic [31:0] wa, input logic [31:0] wd);
		wr_s = 1'b1;
		addr = wa;
		wdata = wd;
		@(posedge clk);
		#1;
	endtask : wr
	// first two unlock cycles
	task automatic pre();
		wr(a_u1, `FCS_D_UNLK1);
		wr({16'h0000, `FCS_A_UNLK2}, `FCS_D_UNLK2);
	endtask : pre
	// six-cycle sequence
	task automatic six(input logic [31:0] d3, input logic [31:0] a6, input logic [31:0] d6);
		pre();
		wr(a_u1, d3);
		pre();
		wr(a6, d6);
	endtask : six
	// snapshot of the array tally
	task automatic mark();
		c0 = cnt;
		b0 = bcnt;
		s0 = sum;
	endtask : mark
	// release strobe, expect busy, then bounded wait for ready
	task automatic run();
		int n;
		n = 0;
		wr_s = 1'b0;
		@(posedge clk);
		#1;
		chk({31'h0, rdy}, 32'h0, "busy flag");
		while (rdy !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({30'h0, rdy, rmode}, 32'h3, "back to read mode");
	endtask : run
	// release strobe, expect nothing started
	task automatic refused();
		wr_s = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk({cnt - c0, 14'h0, rdy, rmode}, 32'h3, "refused op");
	endtask : refused
	// reset with given protect bits and security level
	task automatic do_reset(input logic [5:0] p, input logic s);
		rst_b = 1'b0;
		prot_init = p;
		sec = s;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		@(posedge clk);
		#1;
		chk(status, {10'h000, p, 15'h0000, 1'b1}, "status after reset");
		chk({30'h0, rmode, req}, 32'h2, "read mode after reset");
	endtask : do_reset
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		wr_s = 1'b0;
		addr = 32'h0;
		wdata = 32'h0;
		prot_init = 6'h00;
		sec = 1'b0;
		dly = 4'h3;
		fail_en = 1'b0;
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		exp_sum = 32'h0;
		do_reset(6'h00, 1'b0);
		// page program of page 0x200, slow array, ignored command while running
		mark();
		pre();
		wr(a_u1, `FCS_D_PAGE);
		for (int i = 0; i < 128; i++) begin
			d = (i == 9) ? `FCS_D_RESET : 32'hffffffff - i * 32'h00010001;
			a = 32'h200 + i * 4;
			exp_sum = exp_sum + (a ^ ~d);
			wr(a, d);
			// mode output trails the third command edge by one cycle
			if (i == 0) chk({31'h0, rmode}, 32'h0, "page mode entered");
		end
		pre();
		wr(a_u1, `FCS_D_PAGE);
		run();
		chk({16'h0, cnt - c0}, 32'd128, "page word count");
		chk(sum - s0, exp_sum, "page words and order");
		// broken sequence, then block erase of block 1
		wr(a_u1, `FCS_D_UNLK1);
		wr(a_u1, 32'h0000_0011);
		mark();
		six(`FCS_D_ERASE, 32'h0000_8000, `FCS_D_BLOCK);
		run();
		chk({bcnt - b0, cnt - c0}, 32'h0001_0001, "block erase steps");
		chk(sum - s0, 32'h0000_8000, "block erase base");
		// protect block 0, reset data on the seventh cycle
		six(`FCS_D_PPROG, a_u1, `FCS_D_PPROG);
		wr(32'h0, `FCS_D_RESET);
		run();
		chk({26'h0, pbits}, 32'h1, "block 0 protected");
		// protected block refuses erase and page program
		mark();
		six(`FCS_D_ERASE, 32'h0, `FCS_D_BLOCK);
		refused();
		pre();
		wr(a_u1, `FCS_D_PAGE);
		wr(32'h0, 32'h0);
		refused();
		// chip erase skips block 0, prompt array
		dly = 4'h0;
		six(`FCS_D_ERASE, a_u1, `FCS_D_CHIP);
		run();
		chk({16'h0, bcnt - b0}, 32'd5, "chip erase blocks");
		chk(sum - s0, 32'h000d_8000, "chip erase bases");
		// failing block erase locks until reset
		dly = 4'h2;
		fail_en = 1'b1;
		six(`FCS_D_ERASE, 32'h0001_0000, `FCS_D_BLOCK);
		wr_s = 1'b0;
		repeat (60) @(posedge clk);
		#1;
		chk({30'h0, rdy, rmode}, 32'h0, "locked after failure");
		fail_en = 1'b0;
		// host redoes the interrupted erase after the reset
		do_reset(6'h01, 1'b0);
		six(`FCS_D_ERASE, 32'h0001_0000, `FCS_D_BLOCK);
		run();
		do_reset(6'h3f, 1'b0);
		// all protected: chip erase does nothing
		mark();
		six(`FCS_D_ERASE, a_u1, `FCS_D_CHIP);
		refused();
		// protect erase without security clears bits only
		six(`FCS_D_PERASE, a_u1, `FCS_D_PERASE);
		wr(32'h0, `FCS_D_PERASE);
		run();
		chk({bcnt - b0, 10'h0, pbits}, 32'h0, "plain protect erase");
		// protect erase with security and all protected erases every block
		do_reset(6'h3f, 1'b1);
		mark();
		six(`FCS_D_PERASE, a_u1, `FCS_D_PERASE);
		wr(32'h0, `FCS_D_PERASE);
		run();
		chk({bcnt - b0, 10'h0, pbits}, 32'h0006_0000, "secure protect erase");
		end_of_test();
	end
endmodule : test_flash_command_sequencer
